// ==== hw/ssc_pkg.sv ====
// Purpose: shared constants and types for the sram sleep mode control block
// Assumes: one clock, synchronous active-high reset
// Notes: cycle figures are counted on the system clock
// Notes on behaviour
// - The sleep request pin is an asynchronous active-high input that sends the device to sleep.
// - The device goes to sleep on the fifth enabled edge after the sleep request pin rises and wakes on the third after it falls.
// - While asleep the device is deselected and starts no read or write.
// - Once asleep every input except the sleep request, clock enable and reset is ignored and data outputs float.
// - Inputs stop being sampled no earlier than two cycles after the request rises.
// - Inputs are sampled again only at least two cycles after the request falls.
// - A cycle is a write when write strobe is low with address advance low, a read when high.
// - A clock edge with the clock enable inactive changes no state and no address.
package ssc_pkg;
  localparam int SSC_SYNC_STAGES = 2;
  localparam int SSC_PDS_CYCLES = 2; // request high to inputs ignored, least
  localparam int SSC_PUS_CYCLES = 2; // request low to inputs sampled, least
  localparam logic [1:0] SSC_CNT_RESET = 2'h0;

  typedef enum logic [3:0] {
    SSC_AWAKE = 4'h1,
    SSC_ENTER = 4'h2,
    SSC_ASLEEP = 4'h4,
    SSC_EXIT = 4'h8
  } ssc_state_t;
endpackage

// ==== hw/ssc_sleep_if.sv ====
// Purpose: carries sleep status from the sequencer to the access core
// Assumes: driven in the system clock domain
// Notes: sleep_mode is the power-down level, ignore_inputs also covers the exit delay
`timescale 1ns/1ps
`default_nettype none
interface ssc_sleep_if;
  logic sleep_mode;
  logic ignore_inputs;
  modport seq (output sleep_mode, output ignore_inputs);
  modport core (input sleep_mode, input ignore_inputs);
endinterface
`default_nettype wire

// ==== hw/ssc_sleep_seq.sv ====
// Purpose: synchronises the sleep request and times entry and exit of sleep
// Assumes: i_clk_en high on every counted edge; request may change at any time
// Notes: a request that drops during the entry delay aborts the entry
`timescale 1ns/1ps
`default_nettype none
module ssc_sleep_seq (
  // clock and reset
  input wire logic i_clk_sys,
  input wire logic i_reset,
  input wire logic i_clk_en,
  // asynchronous request
  input wire logic i_sleep_request,
  // status to the core
  ssc_sleep_if.seq o_slp
);
  typedef struct packed {
    logic sync1;
    logic sync2;
    ssc_pkg::ssc_state_t state;
    logic [1:0] cnt;
  } ssc_seq_t;

  ssc_seq_t s_reg;
  ssc_seq_t s_next;

  // next state; sync1 feeds only sync2
  always_comb begin
    s_next = s_reg;
    s_next.sync1 = i_sleep_request;
    s_next.sync2 = s_reg.sync1;
    unique case (s_reg.state)
      ssc_pkg::SSC_AWAKE: begin
        if (s_reg.sync2) begin
          s_next.state = ssc_pkg::SSC_ENTER;
          s_next.cnt = ssc_pkg::SSC_CNT_RESET;
        end
      end
      ssc_pkg::SSC_ENTER: begin
        if (!s_reg.sync2) begin
          s_next.state = ssc_pkg::SSC_AWAKE;
        end else if (s_reg.cnt == 2'(ssc_pkg::SSC_PDS_CYCLES - 1)) begin
          s_next.state = ssc_pkg::SSC_ASLEEP;
        end else begin
          s_next.cnt = s_reg.cnt + 2'h1;
        end
      end
      ssc_pkg::SSC_ASLEEP: begin
        if (!s_reg.sync2) begin
          s_next.state = ssc_pkg::SSC_EXIT;
          s_next.cnt = ssc_pkg::SSC_CNT_RESET;
        end
      end
      ssc_pkg::SSC_EXIT: begin
        // hold off sampling during exit delay
        if (s_reg.sync2) begin
          s_next.state = ssc_pkg::SSC_ASLEEP;
        end else if (s_reg.cnt == 2'(ssc_pkg::SSC_PUS_CYCLES - 1)) begin
          s_next.state = ssc_pkg::SSC_AWAKE;
        end else begin
          s_next.cnt = s_reg.cnt + 2'h1;
        end
      end
    endcase
  end

  // register; frozen while enable is low
  always_ff @(posedge i_clk_sys) begin
    if (i_reset) begin
      s_reg <= '{sync1: 1'b0, sync2: 1'b0, state: ssc_pkg::SSC_AWAKE,
                 cnt: ssc_pkg::SSC_CNT_RESET};
    end else if (i_clk_en) begin
      s_reg <= s_next;
    end
  end

  // status out; exit delay still ignores inputs
  assign o_slp.sleep_mode = (s_reg.state == ssc_pkg::SSC_ASLEEP);
  assign o_slp.ignore_inputs = (s_reg.state == ssc_pkg::SSC_ASLEEP) ||
                               (s_reg.state == ssc_pkg::SSC_EXIT);

  sequence seq_req_held;
    s_reg.sync2 [*2];
  endsequence

  a_enter_after_two: assert property (@(posedge i_clk_sys) disable iff (i_reset || !i_clk_en)
    $rose(s_reg.sync2) |-> (!o_slp.ignore_inputs) [*2])
    else $error("inputs ignored too soon after sleep request");
  a_sleep_reached: assert property (@(posedge i_clk_sys) disable iff (i_reset || !i_clk_en)
    $rose(s_reg.sync2) ##1 seq_req_held |=> o_slp.sleep_mode)
    else $error("sleep not reached after held request");
  a_sleep_follows_pin: assert property (@(posedge i_clk_sys) disable iff (i_reset || !i_clk_en)
    o_slp.sleep_mode && !s_reg.sync2 |=> !o_slp.sleep_mode)
    else $error("sleep outlasts request");
  a_exit_delay_held: assert property (@(posedge i_clk_sys) disable iff (i_reset || !i_clk_en)
    $fell(s_reg.sync2) && o_slp.ignore_inputs |-> o_slp.ignore_inputs [*2])
    else $error("inputs resumed too soon after request fell");
endmodule // ssc_sleep_seq
`default_nettype wire

// ==== hw/ssc_sram_sleep_ctrl.sv ====
// Purpose: cycle qualification and data output control with sleep handling
// Assumes: synchronous pins sampled on i_clk_sys; i_clk_en is the inverse of the ignore-edge pin
// Notes: the array itself sits outside; this block flags accesses and drives read data
`timescale 1ns/1ps
`default_nettype none
module ssc_sram_sleep_ctrl #(
  parameter int ADDR_W = 18,
  parameter int DATA_W = 36
) (
  // clock, reset, enable
  input wire logic i_clk_sys,
  input wire logic i_reset,
  input wire logic i_clk_en,
  // asynchronous pins
  input wire logic i_sleep_request,
  input wire logic i_oe_n,
  // synchronous control
  input wire logic i_cs1_n,
  input wire logic i_cs2,
  input wire logic i_cs2_n,
  input wire logic i_address_advance,
  input wire logic i_we_n,
  input wire logic [ADDR_W-1:0] i_addr,
  // array side
  input wire logic [DATA_W-1:0] i_array_rdata,
  // access flags
  output logic o_read_start,
  output logic o_write_start,
  output logic o_burst_continue,
  output logic [ADDR_W-1:0] o_addr,
  // data pins
  output logic [DATA_W-1:0] o_dq,
  output logic o_dq_oe,
  output logic o_sleep_mode
);
  typedef struct packed {
    logic selected;
    logic reading;
    logic rd_start;
    logic wr_start;
    logic cont;
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] dq;
  } ssc_core_t;

  ssc_sleep_if slp ();
  ssc_core_t c_reg;
  ssc_core_t c_next;
  logic chip_sel;

  ssc_sleep_seq u_seq (
    .i_clk_sys(i_clk_sys),
    .i_reset(i_reset),
    .i_clk_en(i_clk_en),
    .i_sleep_request(i_sleep_request),
    .o_slp(slp.seq)
  );

  // chip selects count only at edges where address advance is low
  assign chip_sel = !i_cs1_n && i_cs2 && !i_cs2_n;

  // qualify the cycle presented at this edge
  always_comb begin
    c_next = c_reg;
    c_next.rd_start = 1'b0;
    c_next.wr_start = 1'b0;
    c_next.cont = 1'b0;
    if (slp.ignore_inputs) begin
      // pins are not looked at while asleep
      c_next.selected = 1'b0;
      c_next.reading = 1'b0;
    end else if (!i_address_advance) begin
      // strobe level at advance low picks the cycle kind
      c_next.selected = chip_sel;
      c_next.reading = chip_sel && i_we_n;
      c_next.rd_start = chip_sel && i_we_n;
      c_next.wr_start = chip_sel && !i_we_n;
      if (chip_sel) begin
        c_next.addr = i_addr;
      end
    end else begin
      // continue a burst only from a selected cycle
      c_next.cont = c_reg.selected;
    end
    // read data is pipelined one edge behind the start
    if (c_reg.reading && !slp.ignore_inputs) begin
      c_next.dq = i_array_rdata;
    end
  end

  // a disabled edge leaves state and address alone
  always_ff @(posedge i_clk_sys) begin
    if (i_reset) begin
      c_reg <= '0;
    end else if (i_clk_en) begin
      c_reg <= c_next;
    end
  end

  assign o_read_start = c_reg.rd_start;
  assign o_write_start = c_reg.wr_start;
  assign o_burst_continue = c_reg.cont;
  assign o_addr = c_reg.addr;
  assign o_dq = c_reg.dq;
  assign o_sleep_mode = slp.sleep_mode;
  // outputs float in sleep; output enable pin is asynchronous
  assign o_dq_oe = c_reg.reading && !i_oe_n && !slp.ignore_inputs;

  a_sleep_hiz: assert property (@(posedge i_clk_sys) disable iff (i_reset)
    slp.sleep_mode |-> !o_dq_oe)
    else $error("data driven during sleep");
  a_sleep_no_access: assert property (@(posedge i_clk_sys) disable iff (i_reset || !i_clk_en)
    slp.ignore_inputs |=> !o_read_start && !o_write_start)
    else $error("access started while asleep");
  a_write_class: assert property (@(posedge i_clk_sys) disable iff (i_reset || !i_clk_en)
    !slp.ignore_inputs && chip_sel && !i_address_advance && !i_we_n
      |=> o_write_start && !o_read_start && o_addr == $past(i_addr))
    else $error("write cycle not qualified");
  a_read_class: assert property (@(posedge i_clk_sys) disable iff (i_reset || !i_clk_en)
    !slp.ignore_inputs && chip_sel && !i_address_advance && i_we_n
      |=> o_read_start && !o_write_start)
    else $error("read cycle not qualified");
  a_edge_ignored: assert property (@(posedge i_clk_sys) disable iff (i_reset)
    !i_clk_en |=> $stable(o_addr) && $stable(o_read_start) && $stable(o_sleep_mode))
    else $error("state moved on a disabled edge");
endmodule // ssc_sram_sleep_ctrl
`default_nettype wire

// ==== bench/ssc_ctrl_model.sv ====
// Purpose: memory controller model driving the synchronous pins and the array data
// Assumes: command is changed by the bench at the falling edge
// Notes: 0 continue, 1 read, 2 write, 3 deselect
`timescale 1ns/1ps
`default_nettype none
module ssc_ctrl_model #(
  parameter int ADDR_W = 18,
  parameter int DATA_W = 36
) (
  // bench side
  input wire logic [1:0] i_cmd,
  input wire logic i_exit_window,
  input wire logic [ADDR_W-1:0] i_addr_req,
  input wire logic [ADDR_W-1:0] i_addr_cur,
  // memory pins
  output logic o_cs1_n,
  output logic o_cs2,
  output logic o_cs2_n,
  output logic o_adv,
  output logic o_we_n,
  output logic [ADDR_W-1:0] o_addr,
  output logic [DATA_W-1:0] o_rdata
);
  // pin decode; address is inverted on continue cycles so stale values never look valid
  always_comb begin
    o_cs1_n = (i_cmd == 2'h3);
    o_cs2 = 1'b1;
    o_cs2_n = 1'b0;
    o_adv = (i_cmd == 2'h0);
    // writes held back in exit window
    o_we_n = !((i_cmd == 2'h2) && !i_exit_window);
    o_addr = o_adv ? ~i_addr_req : i_addr_req;
    o_rdata = DATA_W'({i_addr_cur, i_addr_cur});
  end
endmodule // ssc_ctrl_model
`default_nettype wire

// ==== bench/ssc_sram_sleep_ctrl_tb.sv ====
// Purpose: self-checking bench for the sleep and cycle qualification block
// Assumes: pins change at the falling edge, outputs read 5 ns after the rising edge
// Notes: random traffic uses a fixed seed
`timescale 1ns/1ps
`default_nettype none
module ssc_sram_sleep_ctrl_tb;
  localparam int AW = 18;
  localparam int DW = 36;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic en = 1'b1;
  logic slp = 1'b0;
  logic oe_n = 1'b0;
  logic exit_win = 1'b0;
  logic [1:0] cmd = 2'h0;
  logic [AW-1:0] areq = '0;
  logic cs1_n, cs2, cs2_n, address_advance, we_n, rd, wr, bc, dq_oe, smode;
  logic [AW-1:0] pa, ao;
  logic [DW-1:0] rdata, dq;
  int miscompares = 0;
  int cmp_count = 0;
  always #20 clk = ~clk;
  ssc_ctrl_model #(.ADDR_W(AW), .DATA_W(DW)) partner (.i_cmd(cmd), .i_exit_window(exit_win),
    .i_addr_req(areq), .i_addr_cur(ao), .o_cs1_n(cs1_n), .o_cs2(cs2), .o_cs2_n(cs2_n),
    .o_adv(address_advance), .o_we_n(we_n), .o_addr(pa), .o_rdata(rdata));
  ssc_sram_sleep_ctrl #(.ADDR_W(AW), .DATA_W(DW)) dut (.i_clk_sys(clk), .i_reset(rst),
    .i_clk_en(en), .i_sleep_request(slp), .i_oe_n(oe_n), .i_cs1_n(cs1_n), .i_cs2(cs2),
    .i_cs2_n(cs2_n), .i_address_advance(address_advance), .i_we_n(we_n), .i_addr(pa),
    .i_array_rdata(rdata), .o_read_start(rd), .o_write_start(wr), .o_burst_continue(bc),
    .o_addr(ao), .o_dq(dq), .o_dq_oe(dq_oe), .o_sleep_mode(smode));
  task automatic conclude();
    $display("compares %0d miscompares %0d", cmp_count, miscompares);
    if (miscompares == 0 && cmp_count > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask
  task automatic chk(input logic [DW-1:0] got, input logic [DW-1:0] exp);
    cmp_count++;
    if (got !== exp) begin
      miscompares++;
      $display("MISMATCH t=%0t got %h exp %h", $time, got, exp);
    end
  endtask
  // expected start pulses {write, read} for a new cycle that is sampled
  function automatic logic [1:0] exp_pulse(input logic [1:0] c, input logic live);
    return live ? {c == 2'h2, c == 2'h1} : 2'h0;
  endfunction
  // one cycle: drive at the falling edge, check after the rising edge
  task automatic op(input logic [1:0] c, input logic [AW-1:0] a, input logic live,
                    input logic e);
    logic [AW-1:0] prev;
    prev = ao;
    @(negedge clk);
    cmd = c;
    areq = a;
    en = e;
    @(posedge clk);
    #5;
    chk(DW'({wr, rd}), DW'(exp_pulse(c, live && e)));
    if (live && e && c != 2'h0 && c != 2'h3) begin
      chk(DW'(ao), DW'(a));
    end else begin
      chk(DW'(ao), DW'(prev));
    end
  endtask
  initial begin
    void'($urandom(55493));
    repeat (4) @(negedge clk);
    rst = 1'b0;
    // read then continue: data and enable follow
    op(2'h1, 18'h3FFFF, 1'b1, 1'b1);
    op(2'h0, '0, 1'b1, 1'b1);
    chk(DW'(bc), DW'(1));
    chk(dq, DW'({18'h3FFFF, 18'h3FFFF}));
    chk(DW'(dq_oe), DW'(1));
    // enable pin gates drive; the pin is asynchronous, so look 1 ns after it moves
    @(negedge clk);
    oe_n = 1'b1;
    #1;
    chk(DW'(dq_oe), DW'(0));
    @(negedge clk);
    oe_n = 1'b0;
    op(2'h2, 18'h00001, 1'b1, 1'b1);
    op(2'h3, 18'h00002, 1'b1, 1'b1);
    op(2'h1, 18'h00003, 1'b1, 1'b0);
    // idle before sleep; read on the request edge still taken
    @(negedge clk);
    slp = 1'b1;
    op(2'h1, 18'h00ABC, 1'b1, 1'b1);
    repeat (4) op(2'h0, '0, 1'b1, 1'b1);
    chk(DW'({smode, dq_oe}), DW'(2'h2));
    op(2'h1, 18'h00123, 1'b0, 1'b1);
    op(2'h2, 18'h00456, 1'b0, 1'b1);
    // request falls; from here only reads or deselects
    @(negedge clk);
    slp = 1'b0;
    exit_win = 1'b1;
    // one more sync edge, the edge that leaves sleep, then two exit-delay edges, all still ignored
    op(2'h1, 18'h00789, 1'b0, 1'b1);
    op(2'h1, 18'h0078A, 1'b0, 1'b1);
    op(2'h2, 18'h0078B, 1'b0, 1'b1);
    op(2'h1, 18'h0078C, 1'b0, 1'b1);
    chk(DW'(smode), DW'(0));
    exit_win = 1'b0;
    op(2'h1, 18'h2AAAA, 1'b1, 1'b1);
    // random traffic
    repeat (200) begin
      op(2'($urandom_range(3, 0)), AW'($urandom), 1'b1, 1'b1);
    end
    conclude();
  end
  // watchdog: the run needs about 9 us
  initial begin
    #200000;
    miscompares++;
    conclude();
  end
endmodule // ssc_sram_sleep_ctrl_tb
`default_nettype wire
